// [regulator_spi_register_bank_bench.sv]
`timescale 1ns/1ps
`default_nettype none
module regulator_spi_register_bank_bench import rsb_pkg::*; ();
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic cs_n, sck, mosi, miso, miso_oe_n, ff_n, por_n, wdf_n, safety_output_enable, wd_rst;
  logic saw_rst = 1'b0;
  logic [5:0] en_o, en;
  logic [15:0] cfg0, cfg1, d, v, m;
  logic [31:0] diag_evt = 32'h0, det = 32'h0, rx, sr;
  integer seed = 32'hA4B92188;
  int num_errors = 0, n_tests = 0, cyc = 0, k;
  rsb_stat_t st;
  rsb_wdcfg_t wdc;
  logic [15:0] keys [7] = '{16'h00A5, 16'h0011, 16'h005A, 16'h00A5, 16'h005A, 16'h00C3, 16'h003C};

  rsb_regbank #(.SELFTEST_CYCLES(20)) dut_u (.SYS_CLK_I(clk), .RESETN_I(rstn), .SPI_CS_N_I(cs_n),
    .SPI_SCK_I(sck), .SPI_MOSI_I(mosi), .SPI_MISO_O(miso), .SPI_MISO_OE_N_O(miso_oe_n), .STATUS_I(st),
    .DIAG_EVT_I(diag_evt), .DET_DIAG_I(det), .FAULT_FLAG_OE_N_O(ff_n), .POR_OE_N_O(por_n),
    .WD_FAULT_N_O(wdf_n), .POE_O(safety_output_enable), .WD_RESTART_O(wd_rst), .OUT_ENABLE_O(en_o), .SYS_CFG0_O(cfg0),
    .SYS_CFG1_O(cfg1), .WD_CFG_O(wdc));
  rsb_host_model host_u (.clk_i(clk), .miso_i(miso), .miso_oe_n_i(miso_oe_n), .cs_n_o(cs_n),
    .sck_o(sck), .mosi_o(mosi));

  initial begin
    forever #50 clk = ~clk;
  end
  // Bit 3 never toggles, so its detector must fail self-test
  always @(posedge clk) begin
    det <= det ^ 32'hFFFF_FFF7;
    saw_rst <= saw_rst | wd_rst;
    cyc++;
    if (cyc == 30000) begin
      num_errors++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    $display("tests %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  function automatic logic [5:0] nxt(input logic [5:0] e, input logic [15:0] w);
    for (int i = 0; i < 6; i++) begin
      if (w[i] === w[i + 8]) e[i] = w[i];
    end
    return e;
  endfunction : nxt
  task automatic wr(input logic [4:0] a, input logic [15:0] w);
    host_u.xfer({3'b001, a, 3'h0, w, 5'h00}, 32, rx);
  endtask : wr
  // Read data bits are random; the device must ignore them
  task automatic rdv(input logic [4:0] a, output logic [15:0] r);
    host_u.xfer({3'b000, a, 3'h0, 16'($random(seed)), 5'h00}, 32, sr);
    host_u.xfer({3'b000, 5'h0C, 24'h0}, 32, rx);
    chk("valid", 16'(rx[29]), 16'h1);
    r = rx[20:5];
  endtask : rdv

  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    st = '0;
    st.rail = {$random(seed), $random(seed)};
    st.ldo1_ok = 1'b1;
    st.ldo2_ok = 1'b1;
    st.safety_output_enable = 1'b1;
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    repeat (30) @(posedge clk);
    chk("en", 16'(en_o), 16'h0003);
    chk("sel", 16'(wdc.sel), 16'h0);
    chk("ffn", 16'(ff_n), 16'h0);
    rdv(5'h0D, v);
    chk("ver0", v, 16'h0008);
    wr(5'h0D, 16'h0008);
    rdv(5'h0D, v);
    chk("ver0", v, 16'h0);
    chk("ffn", 16'(ff_n), 16'h1);
    for (k = 0; k < 4; k++) begin
      d = (k == 0) ? 16'hFFFF : 16'($random(seed));
      wr(5'h08, d);
      chk("cfg0_o", cfg0, d);
      wr(5'h09, d);
      chk("cfg1_o", cfg1, d & ~16'h01E0);
      rdv(5'h08, v);
      chk("cfg0", v, d);
      rdv(5'h09, v);
      chk("cfg1", v, d & ~16'h01E0);
    end
    wr(5'h08, 16'h0);
    wr(5'h01, 16'hFFFF);
    wr(5'h0F, 16'hFFFF);
    rdv(5'h08, v);
    chk("cfg0", v, 16'h0);
    rdv(5'h07, v);
    chk("key", v, 16'h0);
    en = 6'h03;
    for (k = 0; k < 9; k++) begin
      d = (k == 0) ? 16'h0001 : (k == 2) ? 16'h3F3F : (k == 1 || k == 8) ? 16'h0 : 16'($random(seed));
      wr(5'h06, d);
      en = nxt(en, d);
      chk("en", 16'(en_o), 16'(en));
    end
    st.ldo1_ok <= 1'b0;
    st.ldo2_ok <= 1'b0;
    diag_evt <= 32'h0000_000F;
    repeat (4) @(posedge clk);
    diag_evt <= 32'h0;
    wr(5'h0C, 16'($random(seed)));
    rdv(5'h04, v);
    chk("good", 16'({sr[20], sr[15:14]}), 16'h3);
    chk("ffn", 16'(ff_n), 16'h1);
    wr(5'h04, 16'h000F);
    wr(5'h06, 16'h0303);
    diag_evt <= 32'h0001_0020;
    repeat (4) @(posedge clk);
    diag_evt <= 32'h0;
    repeat (4) @(posedge clk);
    chk("ffn", 16'(ff_n), 16'h0);
    d = 16'($random(seed));
    wr(5'h0C, d);
    rdv(5'h04, v);
    chk("ff", 16'(sr[20]), 16'h1);
    chk("diag0", v, 16'h0020);
    rdv(5'h05, v);
    chk("diag1", v, 16'h0001);
    rdv(5'h0C, v);
    chk("rdbk", v, d);
    for (k = 0; k < 4; k++) begin
      m = (k == 3) ? 16'h07FF : 16'hFFFF;
      rdv(5'(k), v);
      chk("stat", v & m, st.rail[16 * k +: 16] & m);
    end
    wr(5'h04, 16'h0020);
    wr(5'h05, 16'hFFFF);
    rdv(5'h04, v);
    chk("diag0", v, 16'h0);
    chk("ffn", 16'(ff_n), 16'h1);
    host_u.xfer({3'b001, 5'h08, 3'h0, 16'hFFFF, 5'h00}, 31, rx);
    rdv(5'h04, v);
    chk("serr", v, 16'h8000);
    rdv(5'h08, v);
    chk("cfg0", v, 16'h0);
    wr(5'h04, 16'h8000);
    wr(5'h0B, 16'h0001);
    chk("sel", 16'(wdc.sel), 16'h0);
    wr(5'h0A, 16'h002A);
    chk("rand", 16'(wdc.rand_word), 16'h002A);
    st.watchdog_state_field <= 3'h2;
    repeat (8) @(posedge clk);
    chk("sel", 16'(wdc.sel), 16'h1);
    chk("pulse", wdc.pulse, 16'h0001);
    chk("timer", wdc.timer, 16'h002A);
    wr(5'h0B, 16'h0002);
    rdv(5'h0B, v);
    chk("wdpul", v, 16'h0001);
    for (k = 0; k < 7; k++) begin
      wr(5'h07, keys[k]);
      if (k == 2) chk("poe", 16'(safety_output_enable), 16'h1);
      if (k == 4) chk("flash", 16'({por_n, wdf_n, safety_output_enable}), 16'h6);
    end
    chk("restart", 16'({saw_rst, safety_output_enable}), 16'h3);
    tally_and_finish();
  end
endmodule : regulator_spi_register_bank_bench
`default_nettype wire

// [rsb_cfg.svh]
// Operation
// - Latched diagnostic status refreshes only when chip select returns high.
// - Next frame shifts out the sixteen latched diagnostic status bits, or the read data after a valid read.
// - Four status registers are read-only, real-time rail, fault and watchdog state.
// - Watchdog configuration accepts writes only in configuration state, except the random word bits.
// - Watchdog settings apply on leaving configuration, random word immediately.
// - Two-bit field selects watchdog type, pulse width watchdog by default.
// - Pulse watchdog settings at 0x0B; window, question timers and random word at 0x0A.
// - Configuration registers 0x08 and 0x09 steer dither, responses, masks, delays, mux.
// - Each output changes only when its two nonadjacent bits agree.
// - Remote regulators default on; disabled ones have under/overvoltage faults masked.
// - Disabled remote regulator reports its good bit as one.
// - Key sequence enters reprogram mode; any wrong word restarts the sequence.
// - Reprogram mode: reset output high, watchdog fault high, safety enable low.
// - Restart key sequence leaves reprogram mode; watchdog restarts with new setup.
// - Power-up self-test; untoggled detector sets verify bit and pulls fault flag.
// - Writing one clears verify bits and restores the fault flag.
// - Diagnostic registers readable; each bit written with one is cleared.
// - Key register is write-only and reads as zero.
// - Frame bit 29 selects write; reads ignore data bits.
`ifndef RSB_CFG_SVH
`define RSB_CFG_SVH
`define RSB_ADDR_STAT0 5'h00
`define RSB_ADDR_STAT3 5'h03
`define RSB_ADDR_DIAG0 5'h04
`define RSB_ADDR_DIAG1 5'h05
`define RSB_ADDR_ENABLE 5'h06
`define RSB_ADDR_KEY 5'h07
`define RSB_ADDR_CFG0 5'h08
`define RSB_ADDR_CFG1 5'h09
`define RSB_ADDR_WDTIM 5'h0A
`define RSB_ADDR_WDPUL 5'h0B
`define RSB_ADDR_RDBK 5'h0C
`define RSB_ADDR_VER0 5'h0D
`define RSB_ADDR_VER1 5'h0E
`define RSB_FRAME_BITS 6'd32
`define RSB_BIT_WR 29
`define RSB_BIT_CHIP 30
`define RSB_BIT_LEAD 31
`define RSB_RST_ENABLE 16'h0303
`define RSB_RST_CFG 16'h0000
`define RSB_RST_WD 16'h0000
`define RSB_CFG1_UNUSED 16'h01E0
`define RSB_CFG0_MASK_DIAG1 0
`define RSB_WD_RAND_LO 0
`define RSB_WD_RAND_HI 5
`define RSB_WD_LOCK_LO 6
`define RSB_WDSEL_PULSE_WIDTH_WATCHDOG 2'h0
`define RSB_WDSTATE_CONFIG 3'h0
`define RSB_DIAG_SE 15
`define RSB_LDO_FAULT_MASK1 16'h0003
`define RSB_LDO_FAULT_MASK2 16'h000C
`define RSB_KEY_FLASH_0 16'h00A5
`define RSB_KEY_FLASH_1 16'h005A
`define RSB_KEY_RESTART_0 16'h00C3
`define RSB_KEY_RESTART_1 16'h003C
`define RSB_CRC_SEED 5'h1F
`define RSB_CRC_POLY 5'h05
`define RSB_SELFTEST_US 500
`define RSB_CLK_MHZ 10
`endif

// [rsb_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
module rsb_host_model (
  input wire logic clk_i,
  input wire logic miso_i,
  input wire logic miso_oe_n_i,
  output logic cs_n_o,
  output logic sck_o,
  output logic mosi_o
);
  logic last_q = 1'b0;
  initial begin
    cs_n_o = 1'b1;
    sck_o = 1'b1;
    mosi_o = 1'b0;
  end
  // ****************************************
  // Mode 3 frame, clock idles high
  // ****************************************
  task automatic xfer(input logic [31:0] tx, input int nrise, output logic [31:0] rx);
    int i;
    rx = 32'h0;
    @(posedge clk_i);
    cs_n_o <= 1'b0;
    repeat (4) @(posedge clk_i);
    for (i = 0; i < nrise; i++) begin
      sck_o <= 1'b0;
      mosi_o <= tx[31 - (i % 32)];
      repeat (4) @(posedge clk_i);
      sck_o <= 1'b1;
      repeat (4) @(posedge clk_i);
      // Released line reads flipped so a stale bit never passes
      last_q = miso_oe_n_i ? ~last_q : miso_i;
      rx = {rx[30:0], last_q};
    end
    cs_n_o <= 1'b1;
    mosi_o <= ~mosi_o;
    repeat (10) @(posedge clk_i);
  endtask : xfer
endmodule : rsb_host_model
`default_nettype wire

// [rsb_pkg.sv]
package rsb_pkg;
  typedef enum logic {RSB_NORMAL, RSB_FLASH} rsb_mode_t;

  typedef struct packed {
    logic [63:0] rail;
    logic ldo1_ok;
    logic ldo2_ok;
    logic dbe;
    logic enbat;
    logic enb;
    logic wd_fault;
    logic [2:0] watchdog_state_field;
    logic por_n;
    logic wdf_n;
    logic safety_output_enable;
  } rsb_stat_t;

  typedef struct packed {
    logic [1:0] sel;
    logic [15:0] timer;
    logic [15:0] pulse;
    logic [5:0] rand_word;
  } rsb_wdcfg_t;

  typedef struct packed {
    logic lead;
    logic chip;
    logic valid;
    logic [4:0] msg_id;
    logic [2:0] fcnt;
    logic [15:0] data;
    logic [4:0] crc;
  } rsb_resp_t;
endpackage : rsb_pkg

// [rsb_regbank.sv]
`timescale 1ns/1ps
`default_nettype none
`include "rsb_cfg.svh"
module rsb_regbank
  import rsb_pkg::*;
#(
  parameter int unsigned SELFTEST_CYCLES = `RSB_SELFTEST_US * `RSB_CLK_MHZ
) (
  input wire logic SYS_CLK_I,
  input wire logic RESETN_I,
  input wire logic SPI_CS_N_I,
  input wire logic SPI_SCK_I,
  input wire logic SPI_MOSI_I,
  output logic SPI_MISO_O,
  output logic SPI_MISO_OE_N_O,
  input wire rsb_stat_t STATUS_I,
  input wire logic [31:0] DIAG_EVT_I,
  input wire logic [31:0] DET_DIAG_I,
  output logic FAULT_FLAG_OE_N_O,
  output logic POR_OE_N_O,
  output logic WD_FAULT_N_O,
  output logic POE_O,
  output logic WD_RESTART_O,
  output logic [5:0] OUT_ENABLE_O,
  output logic [15:0] SYS_CFG0_O,
  output logic [15:0] SYS_CFG1_O,
  output rsb_wdcfg_t WD_CFG_O
);
  if (SELFTEST_CYCLES < 1) begin : g_chk
    $error("SELFTEST_CYCLES must be at least one");
  end

  // ****************************************
  // Input synchronisers
  // ****************************************
  logic [2:0] spi_s1_q;
  logic [2:0] spi_s2_q;
  logic [2:0] spi_s3_q;
  rsb_stat_t stat_s1_q;
  rsb_stat_t stat_s2_q;
  logic [31:0] evt_s1_q;
  logic [31:0] evt_s2_q;
  logic [31:0] det_s1_q;
  logic [31:0] det_s2_q;
  logic [31:0] det_s3_q;

  always_ff @(posedge SYS_CLK_I) begin
    if (!RESETN_I) begin
      spi_s1_q <= 3'h6;
      spi_s2_q <= 3'h6;
      spi_s3_q <= 3'h6;
      stat_s1_q <= '0;
      stat_s2_q <= '0;
      evt_s1_q <= '0;
      evt_s2_q <= '0;
      det_s1_q <= '0;
      det_s2_q <= '0;
      det_s3_q <= '0;
    end else begin
      spi_s1_q <= {SPI_CS_N_I, SPI_SCK_I, SPI_MOSI_I};
      spi_s2_q <= spi_s1_q;
      spi_s3_q <= spi_s2_q;
      stat_s1_q <= STATUS_I;
      stat_s2_q <= stat_s1_q;
      evt_s1_q <= DIAG_EVT_I;
      evt_s2_q <= evt_s1_q;
      det_s1_q <= DET_DIAG_I;
      det_s2_q <= det_s1_q;
      det_s3_q <= det_s2_q;
    end
  end

  logic cs_n;
  logic cs_fall;
  logic cs_rise;
  logic sck_rise;
  logic sck_fall;
  assign cs_n = spi_s2_q[2];
  assign cs_fall = !spi_s2_q[2] && spi_s3_q[2];
  assign cs_rise = spi_s2_q[2] && !spi_s3_q[2];
  assign sck_rise = !cs_n && spi_s2_q[1] && !spi_s3_q[1];
  assign sck_fall = !cs_n && !spi_s2_q[1] && spi_s3_q[1];

  function automatic logic [4:0] crc5(input logic [25:0] bits);
    logic [4:0] c;
    logic fb;
    c = `RSB_CRC_SEED;
    for (int i = 25; i >= 0; i--) begin
      fb = c[4] ^ bits[i];
      c = {c[3:0], 1'b0};
      if (fb) begin
        c = c ^ `RSB_CRC_POLY;
      end
    end
    return c;
  endfunction : crc5

  // ****************************************
  // Frame receive and transmit
  // ****************************************
  logic [31:0] rx_q;
  logic [31:0] tx_q;
  logic [5:0] bit_cnt_q;
  rsb_resp_t resp_q;

  always_ff @(posedge SYS_CLK_I) begin
    if (!RESETN_I) begin
      rx_q <= '0;
      bit_cnt_q <= '0;
    end else if (cs_fall) begin
      bit_cnt_q <= '0;
    end else if (sck_rise) begin
      rx_q <= {rx_q[30:0], spi_s2_q[0]};
      if (bit_cnt_q <= `RSB_FRAME_BITS) begin
        bit_cnt_q <= bit_cnt_q + 6'd1;
      end
    end
  end

  // Mode 3: first falling edge precedes any sample, so bit 31 is loaded at select
  always_ff @(posedge SYS_CLK_I) begin
    if (!RESETN_I) begin
      tx_q <= '0;
    end else if (cs_fall) begin
      tx_q <= resp_q;
    end else if (sck_fall && bit_cnt_q != 6'd0) begin
      tx_q <= {tx_q[30:0], 1'b0};
    end
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (!RESETN_I) begin
      SPI_MISO_O <= 1'b0;
      SPI_MISO_OE_N_O <= 1'b1;
    end else begin
      SPI_MISO_O <= tx_q[31];
      SPI_MISO_OE_N_O <= cs_n;
    end
  end

  logic frame_ok;
  logic wr_cmt;
  logic rd_cmt;
  logic [4:0] addr;
  logic [15:0] wdata;
  assign frame_ok = cs_rise && bit_cnt_q == `RSB_FRAME_BITS && !rx_q[`RSB_BIT_LEAD] && !rx_q[`RSB_BIT_CHIP];
  assign wr_cmt = frame_ok && rx_q[`RSB_BIT_WR];
  assign rd_cmt = frame_ok && !rx_q[`RSB_BIT_WR];
  assign addr = rx_q[28:24];
  assign wdata = rx_q[20:5];

  // ****************************************
  // Control registers
  // ****************************************
  logic [15:0] enable_q;
  logic [5:0] out_state_q;
  logic [5:0] pair_agree;
  logic [15:0] cfg0_q;
  logic [15:0] cfg1_q;
  logic [15:0] wd_timer_q;
  logic [15:0] wd_pulse_q;
  logic [15:0] rdbk_q;
  logic in_cfg;
  logic in_cfg_q;
  logic cfg_exit;

  assign in_cfg = stat_s2_q.watchdog_state_field == `RSB_WDSTATE_CONFIG;
  assign cfg_exit = in_cfg_q && !in_cfg;
  assign pair_agree = ~(enable_q[5:0] ^ enable_q[13:8]);

  always_ff @(posedge SYS_CLK_I) begin
    if (!RESETN_I) begin
      enable_q <= `RSB_RST_ENABLE;
      cfg0_q <= `RSB_RST_CFG;
      cfg1_q <= `RSB_RST_CFG;
    end else if (wr_cmt) begin
      if (addr == `RSB_ADDR_ENABLE) begin
        enable_q <= wdata;
      end else if (addr == `RSB_ADDR_CFG0) begin
        cfg0_q <= wdata;
      end else if (addr == `RSB_ADDR_CFG1) begin
        cfg1_q <= wdata & ~`RSB_CFG1_UNUSED;
      end
    end
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (!RESETN_I) begin
      out_state_q <= enable_q[5:0];
    end else begin
      for (int i = 0; i < 6; i++) begin
        if (pair_agree[i]) begin
          out_state_q[i] <= enable_q[i];
        end
      end
    end
  end

  // Lock covers all but the random word, which the question protocol rewrites live
  always_ff @(posedge SYS_CLK_I) begin
    if (!RESETN_I) begin
      wd_timer_q <= `RSB_RST_WD;
      wd_pulse_q <= `RSB_RST_WD;
    end else if (wr_cmt) begin
      if (addr == `RSB_ADDR_WDTIM) begin
        wd_timer_q[`RSB_WD_RAND_HI:`RSB_WD_RAND_LO] <= wdata[`RSB_WD_RAND_HI:`RSB_WD_RAND_LO];
        if (in_cfg) begin
          wd_timer_q[15:`RSB_WD_LOCK_LO] <= wdata[15:`RSB_WD_LOCK_LO];
        end
      end else if (addr == `RSB_ADDR_WDPUL && in_cfg) begin
        wd_pulse_q <= wdata;
      end
    end
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (!RESETN_I) begin
      in_cfg_q <= 1'b1;
      WD_CFG_O <= '0;
    end else begin
      in_cfg_q <= in_cfg;
      WD_CFG_O.rand_word <= wd_timer_q[`RSB_WD_RAND_HI:`RSB_WD_RAND_LO];
      if (cfg_exit) begin
        WD_CFG_O.sel <= wd_pulse_q[1:0];
        WD_CFG_O.timer <= wd_timer_q;
        WD_CFG_O.pulse <= wd_pulse_q;
      end
    end
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (!RESETN_I) begin
      rdbk_q <= '0;
    end else if (wr_cmt) begin
      rdbk_q <= wdata;
    end
  end

  // ****************************************
  // Key sequence and reprogram mode
  // ****************************************
  rsb_mode_t mode_q;
  logic key_idx_q;
  logic key_wr;
  logic [15:0] key_exp;
  assign key_wr = wr_cmt && addr == `RSB_ADDR_KEY;

  always_comb begin
    if (mode_q == RSB_FLASH) begin
      key_exp = key_idx_q ? `RSB_KEY_RESTART_1 : `RSB_KEY_RESTART_0;
    end else begin
      key_exp = key_idx_q ? `RSB_KEY_FLASH_1 : `RSB_KEY_FLASH_0;
    end
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (!RESETN_I) begin
      mode_q <= RSB_NORMAL;
      key_idx_q <= 1'b0;
      WD_RESTART_O <= 1'b0;
    end else begin
      WD_RESTART_O <= 1'b0;
      if (key_wr) begin
        if (wdata != key_exp) begin
          key_idx_q <= 1'b0;
        end else if (!key_idx_q) begin
          key_idx_q <= 1'b1;
        end else begin
          key_idx_q <= 1'b0;
          if (mode_q == RSB_FLASH) begin
            mode_q <= RSB_NORMAL;
            WD_RESTART_O <= 1'b1;
          end else begin
            mode_q <= RSB_FLASH;
          end
        end
      end
    end
  end

  // ****************************************
  // Diagnostic and verify registers
  // ****************************************
  logic [15:0] diag0_q;
  logic [15:0] diag1_q;
  logic [31:0] verify_q;
  logic [31:0] toggled_q;
  logic [15:0] diag0_set;
  logic st_busy_q;
  logic [31:0] st_cnt_q;
  logic bad_frame;
  logic [15:0] ldo_mask;

  assign bad_frame = cs_rise && bit_cnt_q != `RSB_FRAME_BITS;
  assign diag0_set = evt_s2_q[15:0] | ({15'h0000, bad_frame} << `RSB_DIAG_SE);
  assign ldo_mask = (out_state_q[0] ? 16'h0000 : `RSB_LDO_FAULT_MASK1) | (out_state_q[1] ? 16'h0000 : `RSB_LDO_FAULT_MASK2);

  // Set wins over a same-cycle clear
  always_ff @(posedge SYS_CLK_I) begin
    if (!RESETN_I) begin
      diag0_q <= '0;
      diag1_q <= '0;
    end else begin
      diag0_q <= (diag0_q & ~((wr_cmt && addr == `RSB_ADDR_DIAG0) ? wdata : 16'h0000)) | diag0_set;
      diag1_q <= (diag1_q & ~((wr_cmt && addr == `RSB_ADDR_DIAG1) ? wdata : 16'h0000)) | evt_s2_q[31:16];
    end
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (!RESETN_I) begin
      st_busy_q <= 1'b1;
      st_cnt_q <= '0;
      toggled_q <= '0;
    end else if (st_busy_q) begin
      toggled_q <= toggled_q | (det_s2_q ^ det_s3_q);
      st_cnt_q <= st_cnt_q + 32'd1;
      if (st_cnt_q == SELFTEST_CYCLES - 1) begin
        st_busy_q <= 1'b0;
      end
    end
  end

  logic st_done;
  assign st_done = st_busy_q && st_cnt_q == SELFTEST_CYCLES - 1;

  always_ff @(posedge SYS_CLK_I) begin
    if (!RESETN_I) begin
      verify_q <= '0;
    end else begin
      verify_q <= (verify_q & ~((wr_cmt && addr == `RSB_ADDR_VER0) ? {16'h0000, wdata} : 32'h0000_0000)
                            & ~((wr_cmt && addr == `RSB_ADDR_VER1) ? {wdata, 16'h0000} : 32'h0000_0000))
                  | (st_done ? ~(toggled_q | (det_s2_q ^ det_s3_q)) : 32'h0000_0000);
    end
  end

  // ****************************************
  // Fault flag, status latch and response
  // ****************************************
  logic gen_fault;
  logic [15:0] diag_live;
  logic [15:0] stat3;
  logic [15:0] diag_latch_q;
  logic [2:0] fcnt_q;

  assign gen_fault = |(diag0_q & ~ldo_mask)
                     | (|diag1_q && !cfg0_q[`RSB_CFG0_MASK_DIAG1]) | |verify_q;
  assign stat3 = {gen_fault, stat_s2_q.wd_fault, stat_s2_q.watchdog_state_field, stat_s2_q.rail[58:48]};
  assign diag_live = {gen_fault, diag0_q[`RSB_DIAG_SE] | bad_frame, stat_s2_q.dbe, stat_s2_q.enbat, stat_s2_q.enb,
                      stat_s2_q.ldo1_ok | !out_state_q[0], stat_s2_q.ldo2_ok | !out_state_q[1],
                      stat_s2_q.wd_fault, stat_s2_q.watchdog_state_field, mode_q == RSB_FLASH, |verify_q, 3'h0};

  always_ff @(posedge SYS_CLK_I) begin
    if (!RESETN_I) begin
      diag_latch_q <= '0;
    end else if (cs_rise) begin
      diag_latch_q <= diag_live;
    end
  end

  logic [15:0] rd_data;
  logic rd_valid;
  always_comb begin
    rd_valid = 1'b1;
    if (addr <= `RSB_ADDR_STAT3) begin
      rd_data = (addr == `RSB_ADDR_STAT3) ? stat3 : stat_s2_q.rail[addr[1:0]*16 +: 16];
    end else if (addr == `RSB_ADDR_DIAG0) begin
      rd_data = diag0_q;
    end else if (addr == `RSB_ADDR_DIAG1) begin
      rd_data = diag1_q;
    end else if (addr == `RSB_ADDR_ENABLE) begin
      rd_data = enable_q;
    end else if (addr == `RSB_ADDR_KEY) begin
      rd_data = 16'h0000;
    end else if (addr == `RSB_ADDR_CFG0) begin
      rd_data = cfg0_q;
    end else if (addr == `RSB_ADDR_CFG1) begin
      rd_data = cfg1_q;
    end else if (addr == `RSB_ADDR_WDTIM) begin
      rd_data = wd_timer_q;
    end else if (addr == `RSB_ADDR_WDPUL) begin
      rd_data = wd_pulse_q;
    end else if (addr == `RSB_ADDR_RDBK) begin
      rd_data = rdbk_q;
    end else if (addr == `RSB_ADDR_VER0) begin
      rd_data = verify_q[15:0];
    end else if (addr == `RSB_ADDR_VER1) begin
      rd_data = verify_q[31:16];
    end else begin
      rd_data = 16'h0000;
      rd_valid = 1'b0;
    end
  end

  logic resp_valid;
  logic [15:0] resp_data;
  assign resp_valid = rd_cmt && rd_valid;
  assign resp_data = resp_valid ? rd_data : diag_live;

  always_ff @(posedge SYS_CLK_I) begin
    if (!RESETN_I) begin
      fcnt_q <= '0;
      resp_q <= '{lead: 1'b1, chip: 1'b0, valid: 1'b0, msg_id: 5'h00, fcnt: 3'h0, data: 16'h0000,
                  crc: crc5({1'b0, 25'h0000000})};
    end else if (cs_rise) begin
      fcnt_q <= fcnt_q + 3'd1;
      resp_q.valid <= resp_valid;
      resp_q.msg_id <= addr;
      resp_q.fcnt <= fcnt_q;
      resp_q.data <= resp_data;
      resp_q.crc <= crc5({1'b0, resp_valid, addr, fcnt_q, resp_data});
    end
  end

  // ****************************************
  // Pin outputs
  // ****************************************
  always_ff @(posedge SYS_CLK_I) begin
    if (!RESETN_I) begin
      FAULT_FLAG_OE_N_O <= 1'b1;
      POR_OE_N_O <= 1'b0;
      WD_FAULT_N_O <= 1'b1;
      POE_O <= 1'b0;
      OUT_ENABLE_O <= '0;
      SYS_CFG0_O <= `RSB_RST_CFG;
      SYS_CFG1_O <= `RSB_RST_CFG;
    end else begin
      FAULT_FLAG_OE_N_O <= !gen_fault;
      POR_OE_N_O <= (mode_q == RSB_FLASH) || stat_s2_q.por_n;
      WD_FAULT_N_O <= (mode_q == RSB_FLASH) || stat_s2_q.wdf_n;
      POE_O <= (mode_q != RSB_FLASH) && stat_s2_q.safety_output_enable;
      OUT_ENABLE_O <= out_state_q;
      SYS_CFG0_O <= cfg0_q;
      SYS_CFG1_O <= cfg1_q;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  a_status_latch: assert property (@(posedge SYS_CLK_I) disable iff (!RESETN_I)
    !cs_rise |=> $stable(diag_latch_q)) else $error("status latch moved outside frame end");
  a_pair_hold: assert property (@(posedge SYS_CLK_I) disable iff (!RESETN_I)
    ((out_state_q ^ $past(out_state_q)) & ~$past(pair_agree)) == 6'h00) else $error("output moved on mismatched pair");
  a_flash_pins: assert property (@(posedge SYS_CLK_I) disable iff (!RESETN_I)
    mode_q == RSB_FLASH |=> POR_OE_N_O && WD_FAULT_N_O && !POE_O) else $error("reprogram pin levels wrong");
  a_wd_lock: assert property (@(posedge SYS_CLK_I) disable iff (!RESETN_I)
    !in_cfg |=> $stable(wd_timer_q[15:`RSB_WD_LOCK_LO]) && $stable(wd_pulse_q)) else $error("locked watchdog reg written");
  a_wd_apply: assert property (@(posedge SYS_CLK_I) disable iff (!RESETN_I)
    $changed(WD_CFG_O.pulse) || $changed(WD_CFG_O.sel) |-> $past(cfg_exit)) else $error("watchdog setting applied early");
  a_ldo_good: assert property (@(posedge SYS_CLK_I) disable iff (!RESETN_I)
    cs_rise && !out_state_q[0] |=> diag_latch_q[10]) else $error("disabled regulator not reported good");
  a_ldo2_good: assert property (@(posedge SYS_CLK_I) disable iff (!RESETN_I)
    cs_rise && !out_state_q[1] |=> diag_latch_q[9]) else $error("disabled second regulator not reported good");
  a_verify_flag: assert property (@(posedge SYS_CLK_I) disable iff (!RESETN_I)
    |verify_q |=> !FAULT_FLAG_OE_N_O) else $error("verify failure not on fault flag");
  a_diag_clear: assert property (@(posedge SYS_CLK_I) disable iff (!RESETN_I)
    wr_cmt && addr == `RSB_ADDR_DIAG1 |=> (diag1_q & $past(wdata) & ~$past(evt_s2_q[31:16])) == 16'h0000)
    else $error("diagnostic bit not cleared");
  a_ro_write: assert property (@(posedge SYS_CLK_I) disable iff (!RESETN_I)
    wr_cmt && (addr <= `RSB_ADDR_STAT3 || addr > `RSB_ADDR_VER1) |=> $stable(enable_q) && $stable(cfg0_q)
    && $stable(cfg1_q) && $stable(wd_pulse_q)) else $error("read-only write changed state");
  a_key_reset: assert property (@(posedge SYS_CLK_I) disable iff (!RESETN_I)
    key_wr && wdata != key_exp |=> !key_idx_q && $stable(mode_q)) else $error("wrong key not restarting");
  a_short_frame: assert property (@(posedge SYS_CLK_I) disable iff (!RESETN_I)
    bad_frame |=> diag0_q[`RSB_DIAG_SE] && $stable(enable_q)) else $error("bad frame not flagged");
endmodule : rsb_regbank
`default_nettype wire
